// [src/npcb_pkg.sv]
// constants for the network parameter control block
// assumes word-wide control words addressed by a three-bit index
package npcb_pkg;
	// control word indexes from the control block base
	localparam logic [2:0] OFS_STATUS = 3'h0;
	localparam logic [2:0] OFS_FLAGS  = 3'h1;
	localparam logic [2:0] OFS_TOTAL  = 3'h2;
	localparam logic [2:0] OFS_DISC   = 3'h3;
	localparam logic [2:0] OFS_MODE   = 3'h4;

	// setting flag field positions
	localparam int B_NETCFG = 0;
	localparam int B_RSV    = 1;
	localparam int B_ERRINV = 2;
	localparam int B_TOPO   = 4;
	localparam int B_FAULTY = 8;
	localparam int B_STOP   = 9;
	localparam int B_SPEED  = 11;
	localparam int B_CPUERR = 12;
	localparam int B_AUTH   = 15;

	// topology codes
	localparam logic [1:0] TOPO_LINE = 2'h0;
	localparam logic [1:0] TOPO_RING = 2'h1;

	// legal ranges
	localparam logic [15:0] TOTAL_MIN = 16'h0002;
	localparam logic [15:0] TOTAL_MAX = 16'h0079;
	localparam logic [15:0] DISC_MIN  = 16'h0001;
	localparam logic [15:0] DISC_MAX  = 16'h0003;
	localparam logic [15:0] MODE_MAX  = 16'h0001;

	// least firmware revision for fast-option features
	localparam logic [7:0] FW_MIN_REV = 8'h04;

	// completion codes
	localparam logic [15:0] ERR_NONE  = 16'h0000;
	localparam logic [15:0] ERR_TOPO  = 16'h0101;
	localparam logic [15:0] ERR_TOTAL = 16'h0102;
	localparam logic [15:0] ERR_DISC  = 16'h0103;
	localparam logic [15:0] ERR_MODE  = 16'h0104;
	localparam logic [15:0] ERR_FWSPD = 16'h0105;
	localparam logic [15:0] ERR_FWMC  = 16'h0106;

	// reset values
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [15:0] RST_TOTAL = 16'h0002;
	localparam logic [15:0] RST_DISC  = 16'h0001;

	// inclusive range test on a control word
	function automatic logic in_range(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction
endpackage

// [src/npcb_check.sv]
// range and revision check of the control words
// assumes the words are stable while its verdict is used
module npcb_check (
	input  wire logic [15:0] flags,
	input  wire logic [15:0] total,
	input  wire logic [15:0] disc,
	input  wire logic [15:0] mode,
	input  wire logic [7:0]  fw_rev,
	input  wire logic        local_st,
	output logic      [15:0] err_code
);
	logic       old_fw; // firmware lacks fast options
	logic [1:0] topo;   // topology field

	assign old_fw = fw_rev < npcb_pkg::FW_MIN_REV;
	assign topo   = flags[npcb_pkg::B_TOPO +: 2];

	// first failing field wins; local station sees only speed
	always_comb begin
		err_code = npcb_pkg::ERR_NONE;
		if (old_fw && flags[npcb_pkg::B_SPEED]) begin
			err_code = npcb_pkg::ERR_FWSPD;
		end else if (local_st) begin
			err_code = npcb_pkg::ERR_NONE;
		end else if (topo != npcb_pkg::TOPO_LINE && topo != npcb_pkg::TOPO_RING) begin
			err_code = npcb_pkg::ERR_TOPO;
		end else if (!npcb_pkg::in_range(total, npcb_pkg::TOTAL_MIN,
			npcb_pkg::TOTAL_MAX)) begin
			err_code = npcb_pkg::ERR_TOTAL;
		end else if (!npcb_pkg::in_range(disc, npcb_pkg::DISC_MIN,
			npcb_pkg::DISC_MAX)) begin
			err_code = npcb_pkg::ERR_DISC;
		end else if (mode > npcb_pkg::MODE_MAX) begin
			err_code = npcb_pkg::ERR_MODE;
		end else if (old_fw && mode[0]) begin
			err_code = npcb_pkg::ERR_FWMC;
		end
	end
endmodule

// [src/npcb_flag.sv]
// completion flag pair that stands for one scan
// assumes scan_end pulses once per controller scan
module npcb_flag (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic report,
	input  wire logic report_err,
	input  wire logic scan_end,
	output logic      done,
	output logic      done_err,
	output logic      busy
);
	logic pend_ff;     // completion waiting for scan end
	logic pend_err_ff; // that completion is an error
	logic done_ff;     // completion flag
	logic err_ff;      // error completion flag

	// hold the result until the next end of scan
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pend_ff     <= 1'b0;
			pend_err_ff <= 1'b0;
		end else if (report) begin
			pend_ff     <= 1'b1;
			pend_err_ff <= report_err;
		end else if (scan_end) begin
			pend_ff     <= 1'b0;
		end
	end

	// raise at one end of scan, drop at the next
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done_ff <= 1'b0;
			err_ff  <= 1'b0;
		end else if (scan_end) begin
			done_ff <= pend_ff;
			err_ff  <= pend_ff && pend_err_ff;
		end
	end

	assign done     = done_ff;
	assign done_err = err_ff;
	assign busy     = pend_ff || done_ff;

	// error flag never stands alone
	property p_err_pair;
		@(posedge clk) disable iff (!rst_n) done_err |-> done;
	endproperty
	a_err_pair: assert property (p_err_pair) else $error("error flag without done");

	// flags hold through the scan and drop at its end
	property p_one_scan;
		@(posedge clk) disable iff (!rst_n)
		(done && scan_end && !pend_ff) |=> !done && !done_err;
	endproperty
	a_one_scan: assert property (p_one_scan) else $error("flag outlived its scan");

	// error flag rises only at end of scan
	property p_err_at_end;
		@(posedge clk) disable iff (!rst_n) $rose(done_err) |-> $past(scan_end);
	endproperty
	a_err_at_end: assert property (p_err_at_end) else $error("error flag off scan end");
endmodule

// [src/npcb_top.sv]
// network parameter control block: decodes and checks control words
// assumes one clock, synchronous inputs, scan end given as a pulse
//
// What this block does
// - status word holds zero or error code
// - bit 0 marks configuration table valid
// - bit 1 marks reserved-station table valid
// - bit 2 marks error-invalid table valid
// - invalid table means default parameters used
// - bits 5:4 choose line/star or ring
// - bit 8 clears or holds faulty-station data
// - bit 9 holds or clears outputs on stop
// - bit 11 picks 1G or 100M link
// - bit 12 clears or holds outputs on error
// - bit 15 restricts to class B only
// - disconnect after 2, 4 or 8 failures
// - fifth word picks unicast or multicast
// - out-of-range field ends with error
// - 100M and multicast need revision 04
// - local station applies bits 8, 9, 11
// - local station ignores others without error
// - done flag one scan, error flag too
// - error flag spans one end-of-scan interval
module npcb_top (
	input  wire logic        CLOCK,
	input  wire logic        RESET_N,
	input  wire logic        WR_EN,
	input  wire logic        RD_EN,
	input  wire logic [2:0]  ADDR,
	input  wire logic [15:0] WDATA,
	output logic      [15:0] RDATA,
	input  wire logic        EXEC_REQ,
	input  wire logic        SCAN_END,
	input  wire logic        LOCAL_ST,
	input  wire logic [7:0]  FW_REV,
	output logic             BUSY,
	output logic             DONE,
	output logic             DONE_ERR,
	output logic             NETCFG_VALID,
	output logic             RSV_VALID,
	output logic             ERRINV_VALID,
	output logic             TOPO_RING,
	output logic             FAULTY_HOLD,
	output logic             STOP_CLEAR,
	output logic             SPEED_100M,
	output logic             CPUERR_HOLD,
	output logic             AUTH_B_ONLY,
	output logic      [6:0]  STATION_TOTAL,
	output logic      [3:0]  DISC_LIMIT,
	output logic             MULTICAST
);
	// instruction sequencing states
	typedef enum logic [3:0] {
		S_IDLE  = 4'h1,
		S_CHECK = 4'h2,
		S_ANN   = 4'h4,
		S_WAIT  = 4'h8
	} npcb_state_t;

	npcb_state_t state_ff;    // current state
	npcb_state_t nxt_state;   // next state

	logic [15:0] status_ff;   // completion status
	logic [15:0] flags_ff;    // setting flag word
	logic [15:0] total_ff;    // station total word
	logic [15:0] disc_ff;     // disconnect threshold word
	logic [15:0] mode_ff;     // cast mode word
	logic [15:0] rdata_ff;    // read data
	logic [15:0] err_code;    // verdict of the checker
	logic        flag_busy;   // completion flags still in flight
	logic        bad;         // verdict is an error
	logic        apply_all;   // full settings take effect
	logic        apply_loc;   // local subset takes effect

	// applied configuration
	logic        netcfg_ff;
	logic        rsv_ff;
	logic        errinv_ff;
	logic        ring_ff;
	logic        faulty_ff;
	logic        stop_ff;
	logic        speed_ff;
	logic        cpuerr_ff;
	logic        auth_ff;
	logic [6:0]  total_app_ff;
	logic [3:0]  disc_app_ff;
	logic        mcast_ff;

	assign bad       = err_code != npcb_pkg::ERR_NONE;
	assign apply_all = (state_ff == S_CHECK) && !bad && !LOCAL_ST;
	assign apply_loc = (state_ff == S_CHECK) && !bad;

	// field checker
	npcb_check u_check (
		.flags    (flags_ff),
		.total    (total_ff),
		.disc     (disc_ff),
		.mode     (mode_ff),
		.fw_rev   (FW_REV),
		.local_st (LOCAL_ST),
		.err_code (err_code)
	);

	// completion flags
	npcb_flag u_flag (
		.clk        (CLOCK),
		.rst_n      (RESET_N),
		.report     (state_ff == S_ANN),
		.report_err (status_ff != npcb_pkg::ERR_NONE),
		.scan_end   (SCAN_END),
		.done       (DONE),
		.done_err   (DONE_ERR),
		.busy       (flag_busy)
	);

	// state advance
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			state_ff <= S_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// request taken only when idle
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE: begin
				if (EXEC_REQ) begin
					nxt_state = S_CHECK;
				end
			end
			S_CHECK: begin
				nxt_state = S_ANN;
			end
			S_ANN: begin
				nxt_state = S_WAIT;
			end
			S_WAIT: begin
				if (!flag_busy) begin
					nxt_state = S_IDLE;
				end
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
	end

	// user-written control words
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			flags_ff <= npcb_pkg::RST_WORD;
			total_ff <= npcb_pkg::RST_TOTAL;
			disc_ff  <= npcb_pkg::RST_DISC;
			mode_ff  <= npcb_pkg::RST_WORD;
		end else if (WR_EN) begin
			if (ADDR == npcb_pkg::OFS_FLAGS) begin
				flags_ff <= WDATA;
			end else if (ADDR == npcb_pkg::OFS_TOTAL) begin
				total_ff <= WDATA;
			end else if (ADDR == npcb_pkg::OFS_DISC) begin
				disc_ff <= WDATA;
			end else if (ADDR == npcb_pkg::OFS_MODE) begin
				mode_ff <= WDATA;
			end
		end
	end

	// completion status written by the block only
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			status_ff <= npcb_pkg::ERR_NONE;
		end else if (state_ff == S_CHECK) begin
			status_ff <= err_code;
		end
	end

	// read port, one cycle after the strobe
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			rdata_ff <= npcb_pkg::RST_WORD;
		end else if (RD_EN) begin
			if (ADDR == npcb_pkg::OFS_STATUS) begin
				rdata_ff <= status_ff;
			end else if (ADDR == npcb_pkg::OFS_FLAGS) begin
				rdata_ff <= flags_ff;
			end else if (ADDR == npcb_pkg::OFS_TOTAL) begin
				rdata_ff <= total_ff;
			end else if (ADDR == npcb_pkg::OFS_DISC) begin
				rdata_ff <= disc_ff;
			end else if (ADDR == npcb_pkg::OFS_MODE) begin
				rdata_ff <= mode_ff;
			end else begin
				rdata_ff <= npcb_pkg::RST_WORD;
			end
		end
	end

	// settings honoured by every station type
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			faulty_ff <= 1'b0;
			stop_ff   <= 1'b0;
			speed_ff  <= 1'b0;
		end else if (apply_loc) begin
			faulty_ff <= flags_ff[npcb_pkg::B_FAULTY];
			stop_ff   <= flags_ff[npcb_pkg::B_STOP];
			speed_ff  <= flags_ff[npcb_pkg::B_SPEED];
		end
	end

	// settings a local station leaves untouched
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			netcfg_ff <= 1'b0;
			rsv_ff    <= 1'b0;
			errinv_ff <= 1'b0;
			ring_ff   <= 1'b0;
			cpuerr_ff <= 1'b0;
			auth_ff   <= 1'b0;
		end else if (apply_all) begin
			// clear table bits select default parameters
			netcfg_ff <= flags_ff[npcb_pkg::B_NETCFG];
			rsv_ff    <= flags_ff[npcb_pkg::B_RSV];
			errinv_ff <= flags_ff[npcb_pkg::B_ERRINV];
			ring_ff   <= flags_ff[npcb_pkg::B_TOPO +: 2]
				== npcb_pkg::TOPO_RING;
			cpuerr_ff <= flags_ff[npcb_pkg::B_CPUERR];
			auth_ff   <= flags_ff[npcb_pkg::B_AUTH];
		end
	end

	// numeric settings of the full station
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			total_app_ff <= npcb_pkg::RST_TOTAL[6:0];
			disc_app_ff  <= 4'h2;
			mcast_ff     <= 1'b0;
		end else if (apply_all) begin
			total_app_ff <= total_ff[6:0];
			disc_app_ff  <= 4'h1 << disc_ff[1:0];
			mcast_ff     <= mode_ff[0];
		end
	end

	assign RDATA         = rdata_ff;
	assign BUSY          = state_ff != S_IDLE;
	assign NETCFG_VALID  = netcfg_ff;
	assign RSV_VALID     = rsv_ff;
	assign ERRINV_VALID  = errinv_ff;
	assign TOPO_RING     = ring_ff;
	assign FAULTY_HOLD   = faulty_ff;
	assign STOP_CLEAR    = stop_ff;
	assign SPEED_100M    = speed_ff;
	assign CPUERR_HOLD   = cpuerr_ff;
	assign AUTH_B_ONLY   = auth_ff;
	assign STATION_TOTAL = total_app_ff;
	assign DISC_LIMIT    = disc_app_ff;
	assign MULTICAST     = mcast_ff;

	// good check leaves zero status
	property p_ok_status;
		@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == S_CHECK && !bad) |=> status_ff == 16'h0000;
	endproperty
	a_ok_status: assert property (p_ok_status) else $error("status not zero");

	// station total above the maximum fails
	property p_total_range;
		@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == S_CHECK && !LOCAL_ST && total_ff > 16'h0079
			&& flags_ff[5:4] < 2'h2 && !(FW_REV < 8'h04 && flags_ff[11]))
		|=> status_ff == npcb_pkg::ERR_TOTAL;
	endproperty
	a_total_range: assert property (p_total_range) else $error("total not refused");

	// error leaves the applied setup alone
	property p_err_keeps;
		@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == S_CHECK && bad) |=> $stable(speed_ff) && $stable(ring_ff)
			&& $stable(disc_app_ff);
	endproperty
	a_err_keeps: assert property (p_err_keeps) else $error("error applied settings");

	// speed follows bit 11 on success
	property p_speed;
		@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == S_CHECK && !bad) |=> speed_ff == $past(flags_ff[11]);
	endproperty
	a_speed: assert property (p_speed) else $error("speed not applied");

	// threshold code maps to failure count
	property p_disc;
		@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == S_CHECK && !bad && !LOCAL_ST && disc_ff == 16'h0003)
		|=> DISC_LIMIT == 4'h8;
	endproperty
	a_disc: assert property (p_disc) else $error("wrong disconnect count");

	// old firmware refuses multicast
	property p_fw_mcast;
		@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == S_CHECK && !LOCAL_ST && FW_REV < 8'h04 && mode_ff == 16'h0001)
		|=> status_ff != 16'h0000;
	endproperty
	a_fw_mcast: assert property (p_fw_mcast) else $error("multicast on old firmware");

	// local station ignores other fields silently
	property p_local;
		@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == S_CHECK && LOCAL_ST && !bad)
		|=> status_ff == 16'h0000 && $stable(ring_ff) && $stable(total_app_ff);
	endproperty
	a_local: assert property (p_local) else $error("local applied extra");

	// no flag in the cycle right after the report, block waits for the scan
	property p_done_after;
		@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == S_ANN) |=> !DONE && !DONE_ERR && state_ff == S_WAIT;
	endproperty
	a_done_after: assert property (p_done_after) else $error("done too early");

	// station total below the floor fails
	property p_total_low;
		@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == S_CHECK && !LOCAL_ST && total_ff < npcb_pkg::TOTAL_MIN
			&& flags_ff[5:4] < 2'h2 && !(FW_REV < 8'h04 && flags_ff[11]))
		|=> status_ff == npcb_pkg::ERR_TOTAL;
	endproperty
	a_total_low: assert property (p_total_low) else $error("low total not refused");

	// done rises only at an end of scan while the block waits
	property p_done_rise;
		@(posedge CLOCK) disable iff (!RESET_N)
		$rose(DONE) |-> $past(SCAN_END) && state_ff == S_WAIT;
	endproperty
	a_done_rise: assert property (p_done_rise) else $error("done off scan end");

	// main scenarios
	c_ok: cover property (@(posedge CLOCK) disable iff (!RESET_N) DONE && !DONE_ERR);
	c_err: cover property (@(posedge CLOCK) disable iff (!RESET_N) DONE_ERR);
	c_local: cover property (@(posedge CLOCK) disable iff (!RESET_N)
		state_ff == S_CHECK && LOCAL_ST);
	c_ring: cover property (@(posedge CLOCK) disable iff (!RESET_N)
		state_ff == S_CHECK && !bad && flags_ff[5:4] == npcb_pkg::TOPO_RING);
	c_old_fw: cover property (@(posedge CLOCK) disable iff (!RESET_N)
		state_ff == S_CHECK && !bad && FW_REV < npcb_pkg::FW_MIN_REV);
endmodule

// [tb/npcb_ctl_model.sv]
// controller scan model: gives the end-of-scan pulse of each program scan
// assumes the bench clock and the active-low synchronous reset
module npcb_ctl_model #(
	parameter int PERIOD = 8
) (
	input  wire logic CLOCK,
	input  wire logic RESET_N,
	output logic      SCAN_END
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt_ff; // cycles into the current scan
	// one-cycle pulse every PERIOD cycles, changed off the sampling edge
	always @(negedge CLOCK) begin
		if (!RESET_N) begin
			cnt_ff <= 0;
			SCAN_END <= 1'b0;
		end else begin
			cnt_ff <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
			SCAN_END <= (cnt_ff == PERIOD - 1);
		end
	end
endmodule

// [tb/testbench.sv]
// self-checking bench of the network parameter control block
// assumes the scan model drives the end-of-scan pulse
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P = 8; // scan length in cycles
	// one table row: words, firmware, station kind, expected status
	typedef struct packed {
		logic [15:0] f;
		logic [15:0] t;
		logic [15:0] d;
		logic [15:0] m;
		logic [7:0]  fw;
		logic        loc;
		logic [15:0] c;
	} npcb_row_t;
	logic        clock    = 1'b0;
	logic        reset_n  = 1'b0;
	logic        wr_en    = 1'b0;
	logic        rd_en    = 1'b0;
	logic        exec_req = 1'b0;
	logic        local_st = 1'b0;
	logic [2:0]  addr     = 3'h0;
	logic [15:0] wdata    = 16'h0000;
	logic [7:0]  fw_rev   = 8'h04;
	logic [15:0] rdata;
	logic        scan_end;
	logic        busy;
	logic        done;
	logic        done_err;
	logic [8:0]  pol;      // table-valid and policy outputs
	logic [6:0]  st_tot;
	logic [3:0]  disc_lim;
	logic        mcast;
	int          n_fail    = 0;
	int          tests_run = 0;
	// applied settings that the outputs should show
	logic [15:0] ef, et, ed, em;
	npcb_row_t   rows[16] = '{
		'{16'h0000, 16'h0002, 16'h0001, 16'h0000, 8'h04, 1'b0, npcb_pkg::ERR_NONE},
		'{16'h9b17, 16'h0079, 16'h0003, 16'h0001, 8'h04, 1'b0, npcb_pkg::ERR_NONE},
		'{16'h0010, 16'h0040, 16'h0002, 16'h0000, 8'h00, 1'b0, npcb_pkg::ERR_NONE},
		'{16'h0020, 16'h0002, 16'h0001, 16'h0000, 8'h04, 1'b0, npcb_pkg::ERR_TOPO},
		'{16'h0030, 16'h0002, 16'h0001, 16'h0000, 8'h04, 1'b0, npcb_pkg::ERR_TOPO},
		'{16'h0000, 16'h0001, 16'h0001, 16'h0000, 8'h04, 1'b0, npcb_pkg::ERR_TOTAL},
		'{16'h0000, 16'h007a, 16'h0001, 16'h0000, 8'h04, 1'b0, npcb_pkg::ERR_TOTAL},
		'{16'h0000, 16'h0002, 16'h0000, 16'h0000, 8'h04, 1'b0, npcb_pkg::ERR_DISC},
		'{16'h0000, 16'h0002, 16'h0004, 16'h0000, 8'h04, 1'b0, npcb_pkg::ERR_DISC},
		'{16'h0000, 16'h0002, 16'h0001, 16'h0002, 8'h04, 1'b0, npcb_pkg::ERR_MODE},
		'{16'h0800, 16'h0002, 16'h0001, 16'h0000, 8'h03, 1'b0, npcb_pkg::ERR_FWSPD},
		'{16'h0000, 16'h0002, 16'h0001, 16'h0001, 8'h03, 1'b0, npcb_pkg::ERR_FWMC},
		'{16'h0030, 16'h0000, 16'h0000, 16'h0000, 8'h04, 1'b0, npcb_pkg::ERR_TOPO},
		'{16'h9b37, 16'h0000, 16'h0007, 16'h0005, 8'h04, 1'b1, npcb_pkg::ERR_NONE},
		'{16'h0800, 16'h0002, 16'h0001, 16'h0000, 8'h03, 1'b1, npcb_pkg::ERR_FWSPD},
		'{16'h0001, 16'h0002, 16'h0001, 16'h0000, 8'h04, 1'b0, npcb_pkg::ERR_NONE}
	};

	always #2 clock = ~clock;

	npcb_ctl_model #(.PERIOD(P)) i_npcb_ctl_model (
		.CLOCK   (clock),
		.RESET_N (reset_n),
		.SCAN_END(scan_end)
	);

	npcb_top i_npcb_top (
		.CLOCK        (clock),
		.RESET_N      (reset_n),
		.WR_EN        (wr_en),
		.RD_EN        (rd_en),
		.ADDR         (addr),
		.WDATA        (wdata),
		.RDATA        (rdata),
		.EXEC_REQ     (exec_req),
		.SCAN_END     (scan_end),
		.LOCAL_ST     (local_st),
		.FW_REV       (fw_rev),
		.BUSY         (busy),
		.DONE         (done),
		.DONE_ERR     (done_err),
		.NETCFG_VALID (pol[8]),
		.RSV_VALID    (pol[7]),
		.ERRINV_VALID (pol[6]),
		.TOPO_RING    (pol[5]),
		.FAULTY_HOLD  (pol[4]),
		.STOP_CLEAR   (pol[3]),
		.SPEED_100M   (pol[2]),
		.CPUERR_HOLD  (pol[1]),
		.AUTH_B_ONLY  (pol[0]),
		.STATION_TOTAL(st_tot),
		.DISC_LIMIT   (disc_lim),
		.MULTICAST    (mcast)
	);

	// compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// verdict and end of run
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// one register write, strobe for one cycle
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(negedge clock);
		wr_en = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clock);
		wr_en = 1'b0;
	endtask

	// one register read, data checked the cycle after
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		@(negedge clock);
		rd_en = 1'b1;
		addr = a;
		@(negedge clock);
		rd_en = 1'b0;
		chk(rdata, e);
	endtask

	// outputs against the applied settings
	task automatic chk_out;
		chk({7'h00, pol}, {7'h00, ef[0], ef[1], ef[2], ef[5:4] == 2'h1, ef[8], ef[9],
			ef[11], ef[12], ef[15]});
		chk({5'h00, disc_lim, st_tot}, {5'h00, 4'h1 << ed[1:0], et[6:0]});
		chk({15'h0000, mcast}, {15'h0000, em[0]});
	endtask

	// run once; a second request while busy when dbl is set
	task automatic run(input logic [15:0] code, input logic dbl);
		int n;
		@(negedge clock);
		exec_req = 1'b1;
		@(negedge clock);
		exec_req = 1'b0;
		if (dbl) begin
			@(negedge clock);
			exec_req = 1'b1;
			@(negedge clock);
			exec_req = 1'b0;
		end
		n = 0;
		while (done !== 1'b1 && n < 4 * P) begin
			@(negedge clock);
			n++;
		end
		if (done !== 1'b1) begin
			n_fail++;
			$display("CHECK FAILED %0t no completion", $time);
			test_done();
		end
		chk({15'h0000, done_err}, {15'h0000, code != 16'h0000});
		n = 0;
		while (done === 1'b1 && n < 2 * P) begin
			@(negedge clock);
			n++;
		end
		chk(16'(n), 16'(P));
		chk({14'h0000, done, done_err}, 16'h0000);
		@(negedge clock);
		@(negedge clock);
		chk({15'h0000, busy}, 16'h0000);
	endtask

	// reset values of words and outputs
	task automatic chk_rst;
		ef = 16'h0000;
		et = 16'h0002;
		ed = 16'h0001;
		em = 16'h0000;
		rd(3'h0, 16'h0000);
		rd(3'h1, 16'h0000);
		rd(3'h2, 16'h0002);
		rd(3'h3, 16'h0001);
		rd(3'h4, 16'h0000);
		chk_out();
	endtask

	initial begin
		int seen;
		repeat (4) @(negedge clock);
		reset_n = 1'b1;
		chk_rst();
		wr(3'h0, 16'hffff);
		rd(3'h0, 16'h0000);
		rd(3'h5, 16'h0000);
		// table of ordinary and error cases
		foreach (rows[i]) begin
			wr(3'h1, rows[i].f);
			wr(3'h2, rows[i].t);
			wr(3'h3, rows[i].d);
			wr(3'h4, rows[i].m);
			fw_rev = rows[i].fw;
			local_st = rows[i].loc;
			run(rows[i].c, 1'b0);
			rd(3'h0, rows[i].c);
			if (rows[i].c == 16'h0000 && rows[i].loc) begin
				ef[8] = rows[i].f[8];
				ef[9] = rows[i].f[9];
				ef[11] = rows[i].f[11];
			end else if (rows[i].c == 16'h0000) begin
				ef = rows[i].f;
				et = rows[i].t;
				ed = rows[i].d;
				em = rows[i].m;
			end
			chk_out();
		end
		// second request while busy gives no extra completion
		run(npcb_pkg::ERR_NONE, 1'b1);
		seen = 0;
		repeat (3 * P) begin
			@(negedge clock);
			if (done !== 1'b0) seen++;
		end
		chk(16'(seen), 16'h0000);
		// reset in mid-instruction
		wr(3'h1, 16'h9b17);
		@(negedge clock);
		exec_req = 1'b1;
		@(negedge clock);
		exec_req = 1'b0;
		@(negedge clock);
		reset_n = 1'b0;
		repeat (4) @(negedge clock);
		reset_n = 1'b1;
		chk({14'h0000, done, busy}, 16'h0000);
		chk_rst();
		test_done();
	end
endmodule
